// [design/hsq_pkg.sv]
// shared constants for the homing sequencer
package hsq_pkg;

  // clock rate, used to turn times into cycle counts
  localparam int unsigned CLK_MHZ = 250;

  // homing method numbers accepted by the sequencer
  localparam logic [7:0] METHOD_REV_LIMIT  = 8'h01;
  localparam logic [7:0] METHOD_FWD_LIMIT  = 8'h02;
  localparam logic [7:0] METHOD_HOME_REV_Z = 8'h03;
  localparam logic [7:0] METHOD_HOME_FWD_Z = 8'h04;
  localparam logic [7:0] METHOD_HOME_REV   = 8'h05;

  // operation modes the drive supports (anything else faults)
  localparam logic [7:0] OPMODE_PROFILE_POS = 8'h01;
  localparam logic [7:0] OPMODE_PROFILE_VEL = 8'h03;
  localparam logic [7:0] OPMODE_HOMING      = 8'h06;
  localparam logic [7:0] OPMODE_CYCLIC_POS  = 8'h08;

  // fault codes and auxiliary codes reported to the master
  localparam logic [15:0] ERR_BASE            = 16'h6000;
  localparam logic [15:0] ERR_HOMING_TIMEOUT  = 16'h602C;
  localparam logic [31:0] AUX_HOMING_TIMEOUT  = 32'h0000_08A1;
  localparam logic [15:0] ERR_BAD_METHOD      = 16'h6058;
  localparam logic [31:0] AUX_BAD_METHOD      = 32'h0000_0E03;
  localparam logic [15:0] ERR_INDEX_LOST      = 16'h604A;
  localparam logic [31:0] AUX_INDEX_LOST      = 32'h0000_0C92;
  localparam logic [15:0] ERR_UNSUPPORTED_OP  = 16'h605A;
  localparam logic [31:0] AUX_UNSUPPORTED_OP  = 32'h0000_0E05;

  // times in milliseconds and their cycle counts (rounded down)
  localparam longint unsigned HOME_TIMEOUT_MS  = 30000;
  localparam longint unsigned INDEX_LOST_MS    = 1000;
  localparam longint unsigned HOME_TIMEOUT_CYC = HOME_TIMEOUT_MS * 64'd1000 * CLK_MHZ;
  localparam longint unsigned INDEX_LOST_CYC   = INDEX_LOST_MS * 64'd1000 * CLK_MHZ;

  // width of the time counters
  localparam int unsigned TMR_W = 40;

  // reset values
  localparam logic [15:0] SPEED_RST = 16'h0000;
  localparam logic [31:0] POS_RST   = 32'h0000_0000;

  // which input the edge searches watch
  typedef enum logic [1:0] {
    SIG_REV  = 2'h0,
    SIG_FWD  = 2'h1,
    SIG_HOME = 2'h2
  } hsq_sig_e;

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_FAST  = 6'b000010,
    ST_DECEL = 6'b000100,
    ST_FALL  = 6'b001000,
    ST_RISE  = 6'b010000,
    ST_INDEX = 6'b100000
  } hsq_state_e;

endpackage

// [design/hsq_homing_sequencer.sv]
`timescale 1ns/1ps

// How it works
// [RULE1] master picks method one to five
// [RULE2] method 1: fast reverse to limit rise, stop
// [RULE3] method 1: slow forward to fall, index
// [RULE4] method 1: limit active skips fast search
// [RULE5] method 2: fast forward to limit rise, stop
// [RULE6] method 2: slow reverse to fall, index
// [RULE7] method 2: limit active skips fast search
// [RULE8] method 3: fast forward, slow reverse, index reverse
// [RULE9] method 3: switch active, slow reverse then index
// [RULE10] method 4: fast forward, slow reverse, index forward
// [RULE11] method 4: active: fall reverse, rise forward, index
// [RULE12] method 5: fast reverse, slow forward, index forward
// [RULE13] method 5: active: slow forward fall, index
// [RULE14] homing too slow raises timeout fault
// [RULE15] bad method number raises method fault
// [RULE16] index missing raises index lost fault
// [RULE17] unsupported operation mode raises mode fault; dropped if a homing fault lands in the same cycle
// [RULE18] faults carry 16-bit code and 32-bit aux
// [RULE19] index ends homing, latches position, signals done
// [RULE20] edges from registered samples, seen once
// [RULE21] high and low speeds are configurable inputs
module hsq_homing_sequencer
  import hsq_pkg::*;
#(
  parameter logic [TMR_W-1:0] HOME_TIMEOUT_CYCLES = HOME_TIMEOUT_CYC[TMR_W-1:0],
  parameter logic [TMR_W-1:0] INDEX_LOST_CYCLES   = INDEX_LOST_CYC[TMR_W-1:0]
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        home_start,          // one-cycle request to start homing
  input  wire logic [7:0]  homing_method,       // method number from the master
  input  wire logic        op_mode_wr,          // one-cycle: new operation mode written
  input  wire logic [7:0]  op_mode,             // requested operation mode
  input  wire logic [15:0] speed_high,          // fast search speed
  input  wire logic [15:0] speed_low,           // slow search speed
  input  wire logic        rev_limit,           // reverse limit switch, high when hit
  input  wire logic        fwd_limit,           // forward limit switch, high when hit
  input  wire logic        home_switch,         // home switch, high when on
  input  wire logic        index_pulse,         // encoder index (Z) pulse
  input  wire logic        at_zero_speed,       // drive reports standstill
  input  wire logic [31:0] position,            // current encoder position
  output logic             motion_en,           // speed command is live
  output logic             dir_reverse,         // 1 = reverse direction
  output logic [15:0]      speed_cmd,           // commanded speed magnitude
  output logic             homing_busy,         // procedure in progress
  output logic             homing_done,         // procedure finished cleanly
  output logic [31:0]      home_position,       // position latched at index
  output logic             fault_valid,         // one-cycle fault report
  output logic [15:0]      fault_code,          // error code of last fault
  output logic [31:0]      fault_aux            // auxiliary code of last fault
);

  // whole module state in one record
  typedef struct packed {
    hsq_state_e         st;          // sequencer state
    hsq_sig_e           sel;         // input the switch searches watch
    logic               fast_rev;    // direction of the fast search
    logic               slow_rev;    // direction of the slow falling-edge search
    logic               idx_rev;     // direction of the index search
    logic               need_rise;   // extra rising-edge pass before index
    logic [2:0]         sw_s;        // registered switch samples
    logic [2:0]         sw_p;        // previous switch samples
    logic               idx_s;       // registered index sample
    logic               idx_p;       // previous index sample
    logic [TMR_W-1:0]   tmo_cnt;     // whole-procedure timer
    logic [TMR_W-1:0]   idx_cnt;     // index search timer
    logic               motion_en;
    logic               dir_reverse;
    logic [15:0]        speed_cmd;
    logic               homing_busy;
    logic               homing_done;
    logic [31:0]        home_position;
    logic               fault_valid;
    logic [15:0]        fault_code;
    logic [31:0]        fault_aux;
  } hsq_regs_s;

  hsq_regs_s r_r;   // registered state
  hsq_regs_s r_nxt; // next state

  // combinational helpers
  logic [2:0] rise;      // rising edges of rev, fwd, home
  logic [2:0] fall;      // falling edges of rev, fwd, home
  logic       sel_rise;  // rising edge of the selected switch
  logic       sel_fall;  // falling edge of the selected switch
  logic       idx_edge;  // index pulse rising edge
  logic       start_lvl; // selected switch level at the start request
  logic       mode_ok;   // requested operation mode is supported

  // edge detect on registered samples only, one hit per transition
  always_comb begin
    rise     = r_r.sw_s & ~r_r.sw_p;  // [RULE20]
    fall     = ~r_r.sw_s & r_r.sw_p;  // [RULE20]
    idx_edge = r_r.idx_s & ~r_r.idx_p;
    sel_rise = rise[r_r.sel];
    sel_fall = fall[r_r.sel];
  end

  // supported operation modes
  always_comb begin
    unique case (op_mode)
      OPMODE_PROFILE_POS,
      OPMODE_PROFILE_VEL,
      OPMODE_HOMING,
      OPMODE_CYCLIC_POS: mode_ok = 1'b1;
      default:           mode_ok = 1'b0;
    endcase
  end

  // switch level at start, by method; sampled copy avoids raw pin glitches
  always_comb begin
    unique case (homing_method)
      METHOD_REV_LIMIT: start_lvl = r_r.sw_s[SIG_REV];
      METHOD_FWD_LIMIT: start_lvl = r_r.sw_s[SIG_FWD];
      default:          start_lvl = r_r.sw_s[SIG_HOME];
    endcase
  end

  // next-state logic
  always_comb begin
    r_nxt = r_r;

    // sample the inputs and keep the last sample for edges
    r_nxt.sw_p  = r_r.sw_s; // [RULE20]
    r_nxt.sw_s  = {home_switch, fwd_limit, rev_limit}; // [RULE20]
    r_nxt.idx_p = r_r.idx_s;
    r_nxt.idx_s = index_pulse;

    // fault report is a single-cycle strobe
    r_nxt.fault_valid = 1'b0;

    // mode fault first; a homing fault in the same cycle overwrites it
    if (op_mode_wr && !mode_ok) begin
      r_nxt.fault_valid = 1'b1; // [RULE17]
      r_nxt.fault_code  = ERR_UNSUPPORTED_OP; // [RULE17]
      r_nxt.fault_aux   = AUX_UNSUPPORTED_OP; // [RULE18]
    end

    // whole-procedure timer runs in every busy state
    if (r_r.st != ST_IDLE) begin
      r_nxt.tmo_cnt = r_r.tmo_cnt + 1'b1;
    end

    unique case (r_r.st)
      // waiting for a start request
      ST_IDLE: begin
        r_nxt.motion_en = 1'b0;
        r_nxt.speed_cmd = SPEED_RST;
        if (home_start) begin
          r_nxt.homing_done = 1'b0;
          r_nxt.tmo_cnt     = '0;
          r_nxt.idx_cnt     = '0;
          r_nxt.need_rise   = 1'b0;
          unique case (homing_method)                        // [RULE1]
            METHOD_REV_LIMIT: begin
              r_nxt.sel      = SIG_REV; // [RULE2]
              r_nxt.fast_rev = 1'b1; // [RULE2]
              r_nxt.slow_rev = 1'b0; // [RULE3]
              r_nxt.idx_rev  = 1'b0; // [RULE3]
            end
            METHOD_FWD_LIMIT: begin
              r_nxt.sel      = SIG_FWD; // [RULE5]
              r_nxt.fast_rev = 1'b0; // [RULE5]
              r_nxt.slow_rev = 1'b1; // [RULE6]
              r_nxt.idx_rev  = 1'b1; // [RULE6]
            end
            METHOD_HOME_REV_Z: begin
              r_nxt.sel      = SIG_HOME;
              r_nxt.fast_rev = 1'b0; // [RULE8]
              r_nxt.slow_rev = 1'b1; // [RULE8]
              r_nxt.idx_rev  = 1'b1; // [RULE9]
            end
            METHOD_HOME_FWD_Z: begin
              r_nxt.sel       = SIG_HOME;
              r_nxt.fast_rev  = 1'b0; // [RULE10]
              r_nxt.slow_rev  = 1'b1; // [RULE10]
              r_nxt.idx_rev   = 1'b0; // [RULE10]
              r_nxt.need_rise = start_lvl; // [RULE11]
            end
            METHOD_HOME_REV: begin
              r_nxt.sel      = SIG_HOME;
              r_nxt.fast_rev = 1'b1; // [RULE12]
              r_nxt.slow_rev = 1'b0; // [RULE12]
              r_nxt.idx_rev  = 1'b0; // [RULE13]
            end
            default: begin
              // unknown method: report and stay idle
              r_nxt.fault_valid = 1'b1; // [RULE15]
              r_nxt.fault_code  = ERR_BAD_METHOD; // [RULE15]
              r_nxt.fault_aux   = AUX_BAD_METHOD; // [RULE18]
            end
          endcase
          if (homing_method >= METHOD_REV_LIMIT && homing_method <= METHOD_HOME_REV) begin
            r_nxt.homing_busy = 1'b1;
            r_nxt.motion_en   = 1'b1;
            if (start_lvl) begin
              // switch already on: skip the fast search
              r_nxt.st          = ST_FALL; // [RULE4] [RULE7] [RULE9]
              r_nxt.speed_cmd   = speed_low; // [RULE21]
              r_nxt.dir_reverse = (homing_method == METHOD_REV_LIMIT) ? 1'b0 : 1'b1;
              if (homing_method == METHOD_HOME_REV) begin
                r_nxt.dir_reverse = 1'b0; // [RULE13]
              end
            end else begin
              r_nxt.st          = ST_FAST; // [RULE2] [RULE5] [RULE8]
              r_nxt.speed_cmd   = speed_high; // [RULE21]
              r_nxt.dir_reverse = (homing_method == METHOD_REV_LIMIT ||
                                   homing_method == METHOD_HOME_REV);
            end
          end
        end
      end

      // fast search for the rising edge
      ST_FAST: begin
        r_nxt.speed_cmd = speed_high; // [RULE21]
        // direction picked at start, held from the latched copy
        r_nxt.dir_reverse = r_r.fast_rev; // [RULE2] [RULE5] [RULE12]
        if (sel_rise) begin
          r_nxt.st        = ST_DECEL; // [RULE2] [RULE5] [RULE12]
          r_nxt.speed_cmd = SPEED_RST;
        end
      end

      // ramp to zero, the drive reports standstill
      ST_DECEL: begin
        r_nxt.speed_cmd = SPEED_RST;
        if (at_zero_speed) begin
          r_nxt.st          = ST_FALL; // [RULE3] [RULE6] [RULE10]
          r_nxt.dir_reverse = r_r.slow_rev;
          r_nxt.speed_cmd   = speed_low; // [RULE21]
        end
      end

      // slow search for the falling edge
      ST_FALL: begin
        r_nxt.speed_cmd = speed_low; // [RULE21]
        if (sel_fall) begin
          r_nxt.idx_cnt = '0;
          if (r_r.need_rise) begin
            // method 4 started on the switch: come back over it forward
            r_nxt.st          = ST_RISE; // [RULE11]
            r_nxt.dir_reverse = 1'b0;
          end else begin
            r_nxt.st          = ST_INDEX; // [RULE3] [RULE6] [RULE8]
            r_nxt.dir_reverse = r_r.idx_rev;
          end
        end
      end

      // forward search for the rising edge (method 4, switch on at start)
      ST_RISE: begin
        r_nxt.speed_cmd = speed_high; // [RULE21]
        if (sel_rise) begin
          r_nxt.st          = ST_INDEX; // [RULE11]
          r_nxt.dir_reverse = r_r.idx_rev;
          r_nxt.speed_cmd   = speed_low;
          r_nxt.idx_cnt     = '0;
        end
      end

      // low speed search for the index pulse
      ST_INDEX: begin
        r_nxt.speed_cmd = speed_low; // [RULE21]
        r_nxt.idx_cnt   = r_r.idx_cnt + 1'b1;
        if (idx_edge) begin
          r_nxt.st            = ST_IDLE; // [RULE19]
          r_nxt.motion_en     = 1'b0; // [RULE19]
          r_nxt.speed_cmd     = SPEED_RST;
          r_nxt.home_position = position; // [RULE19]
          r_nxt.homing_done   = 1'b1; // [RULE19]
          r_nxt.homing_busy   = 1'b0;
        end else if (r_r.idx_cnt >= INDEX_LOST_CYCLES - 1'b1) begin
          // no index within the window: encoder index lost
          r_nxt.st          = ST_IDLE;
          r_nxt.motion_en   = 1'b0;
          r_nxt.speed_cmd   = SPEED_RST;
          r_nxt.homing_busy = 1'b0;
          r_nxt.fault_valid = 1'b1; // [RULE16]
          r_nxt.fault_code  = ERR_INDEX_LOST; // [RULE16]
          r_nxt.fault_aux   = AUX_INDEX_LOST; // [RULE18]
        end
      end
    endcase

    // overall timeout wins over every state except a clean finish or an index-lost fault
    if (r_r.st != ST_IDLE && r_nxt.st != ST_IDLE &&
        r_r.tmo_cnt >= HOME_TIMEOUT_CYCLES - 1'b1) begin
      r_nxt.st          = ST_IDLE;
      r_nxt.motion_en   = 1'b0;
      r_nxt.speed_cmd   = SPEED_RST;
      r_nxt.homing_busy = 1'b0;
      r_nxt.fault_valid = 1'b1; // [RULE14]
      r_nxt.fault_code  = ERR_HOMING_TIMEOUT; // [RULE14]
      r_nxt.fault_aux   = AUX_HOMING_TIMEOUT; // [RULE18]
    end
  end

  // state register; every field has a constant reset value
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r.st            <= ST_IDLE;
      r_r.sel           <= SIG_REV;
      r_r.fast_rev      <= 1'b0;
      r_r.slow_rev      <= 1'b0;
      r_r.idx_rev       <= 1'b0;
      r_r.need_rise     <= 1'b0;
      r_r.sw_s          <= 3'h0;
      r_r.sw_p          <= 3'h0;
      r_r.idx_s         <= 1'b0;
      r_r.idx_p         <= 1'b0;
      r_r.tmo_cnt       <= '0;
      r_r.idx_cnt       <= '0;
      r_r.motion_en     <= 1'b0;
      r_r.dir_reverse   <= 1'b0;
      r_r.speed_cmd     <= SPEED_RST;
      r_r.homing_busy   <= 1'b0;
      r_r.homing_done   <= 1'b0;
      r_r.home_position <= POS_RST;
      r_r.fault_valid   <= 1'b0;
      r_r.fault_code    <= ERR_BASE;
      r_r.fault_aux     <= 32'h0000_0000;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from the state register
  assign motion_en     = r_r.motion_en;
  assign dir_reverse   = r_r.dir_reverse;
  assign speed_cmd     = r_r.speed_cmd;
  assign homing_busy   = r_r.homing_busy;
  assign homing_done   = r_r.homing_done;
  assign home_position = r_r.home_position;
  assign fault_valid   = r_r.fault_valid;
  assign fault_code    = r_r.fault_code;
  assign fault_aux     = r_r.fault_aux;

endmodule

// [verification/hsq_homing_checker.sv]
`timescale 1ns/1ps

// port-level watch on the sequencer, bound into every instance
module hsq_homing_checker
  import hsq_pkg::*;
#(
  parameter logic [TMR_W-1:0] HOME_TIMEOUT_CYCLES = HOME_TIMEOUT_CYC[TMR_W-1:0]
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        home_start,
  input wire logic [7:0]  homing_method,
  input wire logic        op_mode_wr,
  input wire logic [7:0]  op_mode,
  input wire logic [15:0] speed_high,
  input wire logic [15:0] speed_low,
  input wire logic        rev_limit,
  input wire logic        motion_en,
  input wire logic        dir_reverse,
  input wire logic [15:0] speed_cmd,
  input wire logic        homing_busy,
  input wire logic        homing_done,
  input wire logic        fault_valid,
  input wire logic [15:0] fault_code,
  input wire logic [31:0] fault_aux
);
  logic [7:0]       meth_q;   // method of the run in progress
  logic [TMR_W-1:0] busy_cnt; // cycles spent busy so far
  logic             op_ok;    // requested mode is one the drive runs
  logic             meth_bad; // method number outside one to five
  logic             take;     // start accepted this cycle

  assign op_ok    = op_mode inside {OPMODE_PROFILE_POS, OPMODE_PROFILE_VEL,
                                    OPMODE_HOMING, OPMODE_CYCLIC_POS};
  assign meth_bad = homing_method == 8'h00 || homing_method > METHOD_HOME_REV;
  assign take     = home_start && !homing_busy;

  // method latch and busy time; the count bounds the timeout
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meth_q   <= 8'h00;
      busy_cnt <= '0;
    end else begin
      meth_q   <= take ? homing_method : meth_q;
      busy_cnt <= homing_busy ? busy_cnt + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_bad_method_flt: assert property (
    take && meth_bad |=> fault_valid && fault_code == ERR_BAD_METHOD
      && fault_aux == AUX_BAD_METHOD) else $error("bad method not reported");
  chk_opmode_flt: assert property (
    op_mode_wr && !op_ok && !homing_busy && !home_start |=> fault_valid
      && fault_code == ERR_UNSUPPORTED_OP && fault_aux == AUX_UNSUPPORTED_OP)
    else $error("unsupported mode not reported");
  chk_opmode_quiet: assert property (
    op_mode_wr && op_ok && !homing_busy && !home_start |=> !fault_valid)
    else $error("supported mode raised a fault");
  chk_fast_reverse: assert property (
    (!rev_limit) [*3] ##0 (take && homing_method == METHOD_REV_LIMIT) |=> homing_busy
      && motion_en && dir_reverse && speed_cmd == speed_high)
    else $error("method one did not start fast reverse");
  chk_skip_fast: assert property (
    rev_limit [*3] ##0 (take && homing_method == METHOD_REV_LIMIT) |=> motion_en
      && !dir_reverse && speed_cmd == speed_low)
    else $error("method one on limit did not go slow forward");
  chk_rise_decel: assert property (
    homing_busy && meth_q == METHOD_REV_LIMIT && speed_cmd == speed_high
      && $rose(rev_limit) |-> ##[1:3] (motion_en && speed_cmd == 16'h0000))
    else $error("no deceleration after limit edge");
  chk_done_idle: assert property (
    $rose(homing_done) |-> !homing_busy && !motion_en && speed_cmd == 16'h0000)
    else $error("done while still moving");
  chk_fault_range: assert property (
    fault_valid |-> fault_code[15:8] == ERR_BASE[15:8] && fault_aux[31:12] == 20'h00000)
    else $error("fault code out of range");
  chk_fault_hold: assert property (
    !fault_valid |-> $stable(fault_code) && $stable(fault_aux))
    else $error("fault code changed without a report");
  chk_timeout_bound: assert property (
    homing_busy |-> busy_cnt <= HOME_TIMEOUT_CYCLES + 2)
    else $error("busy past the homing time limit");
  chk_fault_stops: assert property (
    fault_valid && (fault_code == ERR_HOMING_TIMEOUT || fault_code == ERR_INDEX_LOST)
      |-> ##[0:1] (!homing_busy && !homing_done)) else $error("run kept going after fault");

  cov_done:    cover property ($rose(homing_done));
  cov_timeout: cover property (fault_valid && fault_code == ERR_HOMING_TIMEOUT);
  cov_badm:    cover property (fault_valid && fault_code == ERR_BAD_METHOD);
endmodule

bind hsq_homing_sequencer hsq_homing_checker #(.HOME_TIMEOUT_CYCLES(HOME_TIMEOUT_CYCLES)) i_chk (.*);

// [verification/hsq_axis_model.sv]
`timescale 1ns/1ps

// one-axis stand-in: a count per cycle, switches and index from position
module hsq_axis_model #(
  parameter int REV_AT = -40, // reverse limit on at or below
  parameter int FWD_AT = 120, // forward limit on at or above
  parameter int H_LO   = 40,  // home switch span, low end
  parameter int H_HI   = 70   // home switch span, high end
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        motion_en,
  input  wire logic        dir_reverse,
  input  wire logic [15:0] speed_cmd,
  input  wire logic        load_pos,    // preset the axis
  input  wire logic [31:0] pos_init,
  input  wire logic        stall,       // axis jammed, slow case
  input  wire logic        idx_en,      // encoder index present
  output logic             rev_limit,
  output logic             fwd_limit,
  output logic             home_switch,
  output logic             index_pulse,
  output logic             at_zero_speed,
  output logic [31:0]      position
);
  logic signed [31:0] pos_r;  // axis position
  logic [1:0]         zc_r;   // cycles without a speed command
  logic               moving; // drive is pushing the axis

  assign moving = motion_en && speed_cmd != 16'h0000;

  // stops at once, but standstill is reported a few cycles late
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_r <= 32'h0000_0000;
      zc_r  <= 2'h0;
    end else begin
      if (load_pos) begin
        pos_r <= pos_init;
      end else if (moving && !stall) begin
        pos_r <= dir_reverse ? pos_r - 1 : pos_r + 1;
      end
      zc_r <= moving ? 2'h0 : (zc_r == 2'h3 ? zc_r : zc_r + 2'h1);
    end
  end

  assign at_zero_speed = zc_r == 2'h3;
  assign position      = pos_r;
  assign rev_limit     = pos_r <= REV_AT;
  assign fwd_limit     = pos_r >= FWD_AT;
  assign home_switch   = pos_r >= H_LO && pos_r <= H_HI;
  // one index every 16 counts; held low when the encoder loses it
  assign index_pulse   = idx_en && pos_r[3:0] == 4'h0;
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps

// master side: runs every method, fault path and mode write
module testbench;
  import hsq_pkg::*;

  logic        sys_clk, rst_n, home_start, op_mode_wr, load_pos, stall, idx_en;
  logic        rev_limit, fwd_limit, home_switch, index_pulse, at_zero_speed;
  logic        motion_en, dir_reverse, homing_busy, homing_done, fault_valid;
  logic [7:0]  homing_method, op_mode;
  logic [15:0] speed_high, speed_low, speed_cmd, fault_code;
  logic [31:0] pos_init, position, home_position, fault_aux;
  logic [15:0] exp_q[$]; // fault codes still to be reported
  int          n_fail, n_checks, n;

  // short limits: 2000 and 200 cycles
  hsq_homing_sequencer #(.HOME_TIMEOUT_CYCLES(40'h7D0), .INDEX_LOST_CYCLES(40'hC8)) i_dut (.*);
  hsq_axis_model i_axis (.*); // default geometry

  always #2 sys_clk = ~sys_clk;

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  function automatic logic [31:0] aux_of(input logic [15:0] c);
    case (c)
      ERR_HOMING_TIMEOUT: return AUX_HOMING_TIMEOUT;
      ERR_BAD_METHOD:     return AUX_BAD_METHOD;
      ERR_INDEX_LOST:     return AUX_INDEX_LOST;
      default:            return AUX_UNSUPPORTED_OP;
    endcase
  endfunction

  function automatic bit on_sw(input int m, input int p);
    if (m == 1) return p <= -40;
    if (m == 2) return p >= 120;
    return p >= 40 && p <= 70;
  endfunction

  // walks the search order over the geometry; overshoot is ignored
  function automatic int ref_home(input int m, input int p);
    bit act;
    int df;
    int di;
    act = on_sw(m, p);
    df  = (m == 1 || m == 5) ? -1 : 1;
    di  = (m == 2 || m == 3) ? -1 : 1;
    if (!act) while (!on_sw(m, p)) p += df;
    while (on_sw(m, p)) p -= df;
    if (m == 4 && act) while (!on_sw(m, p)) p++;
    while (p % 16 != 0) p += di;
    return p;
  endfunction

  // every fault pulse must match the head of the queue
  always @(negedge sys_clk) begin
    if (rst_n === 1'b1 && fault_valid !== 1'b0) begin
      if (exp_q.size() == 0) begin
        check("unexpected fault", 32'h0, {16'h0, fault_code});
      end else begin
        check("fault_code", {16'h0, exp_q[0]}, {16'h0, fault_code});
        check("fault_aux", aux_of(exp_q.pop_front()), fault_aux);
      end
    end
  end

  // preset axis, pick fresh speeds, then one start pulse
  task automatic go(input int m, input int p);
    pos_init   = 32'(p);
    load_pos   = 1'b1;
    speed_high = 16'h0100 + 16'($urandom_range(16'hEFFF));
    speed_low  = 16'h0001 + 16'($urandom_range(16'h00FE));
    @(negedge sys_clk);
    load_pos = 1'b0;
    repeat (3) @(negedge sys_clk);
    home_start    = 1'b1;
    homing_method = 8'(m);
    @(negedge sys_clk);
    home_start = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic wait_idle();
    for (n = 0; n < 2500 && homing_busy !== 1'b0; n++) @(negedge sys_clk);
    if (homing_busy !== 1'b0) n_fail++; // run never ended
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard, far beyond the expected few thousand cycles
  initial begin
    #80000;
    n_fail++;
    give_verdict();
  end

  initial begin
    int tm[10] = '{1, 1, 2, 2, 3, 3, 4, 4, 5, 5};
    int tp[10] = '{0, -50, 100, 130, 0, 50, 0, 50, 100, 50};
    logic [7:0] bad[5];
    logic signed [31:0] d;
    {sys_clk, rst_n, home_start, op_mode_wr, load_pos, stall} = '0;
    {homing_method, op_mode, speed_high, speed_low, pos_init} = '0;
    idx_en = 1'b1;
    void'($urandom(32'h3E2B));
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    check("fault_code rst", {16'h0, ERR_BASE}, {16'h0, fault_code});
    check("fault_aux rst", 32'h0, fault_aux);
    // each method, switch off and on at start
    foreach (tm[i]) begin
      go(tm[i], tp[i]);
      wait_idle();
      check("homing_done", 32'h1, {31'h0, homing_done});
      check("motion_en", 32'h0, {31'h0, motion_en});
      d = $signed(home_position) - 32'(ref_home(tm[i], tp[i]));
      check("home_position near", 32'h1, {31'h0, (d >= -2 && d <= 2)});
      $display("test method %0d from %0d ended", tm[i], tp[i]);
    end
    // method numbers outside one to five
    bad = '{8'h00, 8'h06, 8'h07, 8'hFF, 8'h06 + 8'($urandom_range(249))};
    foreach (bad[i]) begin
      exp_q.push_back(ERR_BAD_METHOD);
      go(int'(bad[i]), 0);
      check("busy bad method", 32'h0, {31'h0, homing_busy});
    end
    $display("test bad methods ended");
    // mode writes back to back, every code up to 15 and one random
    for (int i = 0; i < 17; i++) begin
      op_mode = (i < 16) ? 8'(i) : 8'($urandom);
      if (!(op_mode inside {8'h01, 8'h03, 8'h06, 8'h08})) exp_q.push_back(ERR_UNSUPPORTED_OP);
      op_mode_wr = 1'b1;
      @(negedge sys_clk);
    end
    op_mode_wr = 1'b0;
    repeat (3) @(negedge sys_clk);
    $display("test operation modes ended");
    // jammed axis: the search never ends
    stall = 1'b1;
    exp_q.push_back(ERR_HOMING_TIMEOUT);
    go(1, 0);
    wait_idle();
    check("timeout span", 32'h1, {31'h0, n >= 1990 && n <= 2010});
    check("done after timeout", 32'h0, {31'h0, homing_done});
    stall = 1'b0;
    $display("test homing timeout ended");
    // encoder index gone for the whole run, so the last phase misses it
    idx_en = 1'b0;
    exp_q.push_back(ERR_INDEX_LOST);
    go(3, 50);
    wait_idle();
    check("index lost span", 32'h1, {31'h0, n >= 200 && n <= 240});
    check("done after index loss", 32'h0, {31'h0, homing_done});
    idx_en = 1'b1;
    repeat (3) @(negedge sys_clk);
    check("faults left", 32'h0, 32'(exp_q.size()));
    $display("test index loss ended");
    give_verdict();
  end
endmodule
